// File: hdl/sspsc_map.vh
// Purpose: Register offsets, field positions, reset values and mode codes
//          of the serial port status and control block.
// Assumes: Byte addressing on a 32-bit Wishbone bus, one register per word.
// Notes:   Included by the block's design file only.
`ifndef SSPSC_MAP_VH
`define SSPSC_MAP_VH

// ==========================================================================
// Register byte addresses
`define SSPSC_ADDR_W 12
`define SSPSC_ADR_BUF 12'h78C
`define SSPSC_ADR_CON1 12'h790
`define SSPSC_ADR_STAT 12'h794

// ==========================================================================
// Control register one fields
`define SSPSC_C1_WRITE_COLLISION_FLAG 7
`define SSPSC_C1_OVF 6
`define SSPSC_C1_EN 5
`define SSPSC_C1_CKP 4
`define SSPSC_C1_MODE_HI 3
`define SSPSC_C1_MODE_LO 0
`define SSPSC_C1_RESET 8'h00

// ==========================================================================
// Status register fields
`define SSPSC_ST_STOP 4
`define SSPSC_ST_START 3
`define SSPSC_ST_RW 2
`define SSPSC_ST_UA 1
`define SSPSC_ST_BF 0
`define SSPSC_ST_RESET 8'h00

// ==========================================================================
// Mode selector codes
`define SSPSC_M_SPI_H_DIV4 4'h0
`define SSPSC_M_SPI_H_DIV16 4'h1
`define SSPSC_M_SPI_H_DIV64 4'h2
`define SSPSC_M_SPI_H_TMR 4'h3
`define SSPSC_M_SPI_C_SEL 4'h4
`define SSPSC_M_SPI_C_NOSEL 4'h5
`define SSPSC_M_I2C_C7 4'h6
`define SSPSC_M_I2C_C10 4'h7
`define SSPSC_M_I2C_H 4'h8
`define SSPSC_M_SPI_H_BRG 4'hA
`define SSPSC_M_I2C_FWH 4'hB
`define SSPSC_M_I2C_C7_SP 4'hE
`define SSPSC_M_I2C_C10_SP 4'hF

`endif

// File: hdl/sspsc_top.v
// Purpose: Status flags and control register one of a combined SPI / I2C
//          synchronous serial port, with the data buffer and bus-condition
//          detection that feed those flags.
// Assumes: Shift and sequencing engine sits beside this block on core_clk
//          and reports byte and address events as one-cycle pulses.
// Notes:   Serial pins arrive asynchronously and pass two flip-flops.
`timescale 1ns/1ps
`include "sspsc_map.vh"

module sspsc_top #(
  parameter SYNC_STAGES = 2
) (
  // Clock, reset, enable
  input wire core_clk,
  input wire srst,
  input wire clk_en,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`SSPSC_ADDR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  // Serial pins
  input wire serial_clock_pin_i,
  output wire serial_clock_pin_o,
  output wire serial_clock_pin_oe,
  input wire serial_data_pin_i,
  input wire client_select_pin_n_i,
  // Shift engine events
  input wire eng_tx_busy_i,
  input wire eng_tx_done_i,
  input wire eng_rx_done_i,
  input wire [7:0] eng_rx_byte_i,
  input wire eng_addr_match_i,
  input wire eng_addr_rw_i,
  input wire eng_nack_i,
  input wire eng_addr_reload_set_i,
  input wire eng_addr_reload_clr_i,
  input wire eng_sck_i,
  input wire [4:0] seq_requests_i,
  // Shift engine control
  output reg tx_load_o,
  output reg [7:0] tx_data_o,
  output wire port_enable_o,
  output wire [3:0] port_mode_select_o,
  output wire port_active_o,
  output wire spi_client_selected_o,
  output wire cond_event_o
);

  // ========================================================================
  // Pin synchronisers
  // Third stage only feeds edge detection, so stage one is read by stage two alone.
  wire [2:0] pin_raw;
  wire [2:0] pin_s;
  wire [2:0] pin_p;
  assign pin_raw = {client_select_pin_n_i, serial_data_pin_i, serial_clock_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      always @(posedge core_clk) begin
        if (srst) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          s3_q <= 1'b1;
        end else if (clk_en) begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      assign pin_s[gi] = s2_q;
      assign pin_p[gi] = s3_q;
    end
  endgenerate

  wire scl_now = pin_s[0];
  wire scl_prev = pin_p[0];
  wire sda_now = pin_s[1];
  wire sda_prev = pin_p[1];
  wire sel_n_now = pin_s[2];

  // ========================================================================
  // Control register one state
  reg write_collision_flag_q;
  reg ovf_q;
  reg en_q;
  reg ckp_q;
  reg [3:0] mode_q;

  // ========================================================================
  // Mode decode
  reg mode_spi_host;
  reg mode_spi_client;
  reg mode_i2c_client;
  reg mode_i2c_ten;
  reg mode_i2c_host;
  reg mode_cond_events;
  wire mode_i2c;

  always @* begin
    mode_spi_host = 1'b0;
    mode_spi_client = 1'b0;
    mode_i2c_client = 1'b0;
    mode_i2c_ten = 1'b0;
    mode_i2c_host = 1'b0;
    mode_cond_events = 1'b0;
    case (mode_q)
      `SSPSC_M_SPI_H_DIV4, `SSPSC_M_SPI_H_DIV16, `SSPSC_M_SPI_H_DIV64, `SSPSC_M_SPI_H_TMR,
      `SSPSC_M_SPI_H_BRG: begin
        mode_spi_host = 1'b1;
      end
      `SSPSC_M_SPI_C_SEL, `SSPSC_M_SPI_C_NOSEL: begin
        mode_spi_client = 1'b1;
      end
      `SSPSC_M_I2C_C7: begin
        mode_i2c_client = 1'b1;
      end
      `SSPSC_M_I2C_C10: begin
        mode_i2c_client = 1'b1;
        mode_i2c_ten = 1'b1;
      end
      `SSPSC_M_I2C_C7_SP: begin
        mode_i2c_client = 1'b1;
        mode_cond_events = 1'b1;
      end
      `SSPSC_M_I2C_C10_SP: begin
        mode_i2c_client = 1'b1;
        mode_i2c_ten = 1'b1;
        mode_cond_events = 1'b1;
      end
      `SSPSC_M_I2C_H, `SSPSC_M_I2C_FWH: begin
        mode_i2c_host = 1'b1;
      end
      default: begin
        mode_spi_host = 1'b0;
      end
    endcase
  end

  assign mode_i2c = mode_i2c_client || mode_i2c_host;
  // Reserved codes decode to no mode at all; the clock pin stays idle, but buffer writes and received bytes still act while enabled
  wire mode_host = mode_spi_host || mode_i2c_host;

  // ========================================================================
  // Bus condition detection
  // Start is SDA falling while SCL stays high; Stop is SDA rising likewise.
  wire i2c_live = en_q && mode_i2c;
  wire cond_start = i2c_live && scl_now && scl_prev && sda_prev && !sda_now;
  wire cond_stop = i2c_live && scl_now && scl_prev && !sda_prev && sda_now;

  reg start_q;
  reg stop_q;
  reg cond_evt_q;

  always @(posedge core_clk) begin
    if (srst) begin
      start_q <= 1'b0;
      stop_q <= 1'b0;
      cond_evt_q <= 1'b0;
    end else if (clk_en) begin
      cond_evt_q <= mode_cond_events && (cond_start || cond_stop);
      if (!en_q) begin
        start_q <= 1'b0;
        stop_q <= 1'b0;
      end else if (cond_start) begin
        start_q <= 1'b1;
        stop_q <= 1'b0;
      end else if (cond_stop) begin
        stop_q <= 1'b1;
        start_q <= 1'b0;
      end
    end
  end

  assign cond_event_o = cond_evt_q;

  // ========================================================================
  // Wishbone slave
  // Ack follows one cycle after the request; side effects land on the ack edge.
  reg ack_q;
  wire req = wb_cyc_i && wb_stb_i;
  wire hit_buf = ({wb_adr_i[`SSPSC_ADDR_W-1:2], 2'b00} == `SSPSC_ADR_BUF);
  wire hit_con1 = ({wb_adr_i[`SSPSC_ADDR_W-1:2], 2'b00} == `SSPSC_ADR_CON1);
  wire hit_stat = ({wb_adr_i[`SSPSC_ADDR_W-1:2], 2'b00} == `SSPSC_ADR_STAT);
  wire do_acc = req && ack_q;
  wire do_wr = do_acc && wb_we_i && wb_sel_i[0];
  wire wr_con1 = do_wr && hit_con1;
  wire wr_buf = do_wr && hit_buf;
  wire rd_buf = do_acc && !wb_we_i && hit_buf;

  assign wb_ack_o = ack_q;

  // ========================================================================
  // Status bits
  reg rw_client_q;
  reg ua_q;
  reg bf_q;
  reg [7:0] rxbuf_q;

  reg rw_flag;

  // I2C host shows transmit activity, I2C client the captured direction bit; SPI modes read zero
  always @* begin
    if (mode_i2c_host)
      rw_flag = eng_tx_busy_i;
    else if (mode_i2c_client)
      rw_flag = rw_client_q;
    else
      rw_flag = 1'b0;
  end
  wire ua_flag = mode_i2c_ten && ua_q;
  wire [7:0] stat_val = {3'b000, stop_q, start_q, rw_flag, ua_flag, bf_q};
  wire [7:0] con1_val = {write_collision_flag_q, ovf_q, en_q, ckp_q, mode_q};

  assign port_active_o = rw_flag || (|seq_requests_i);

  // ========================================================================
  // Bus register process
  always @(posedge core_clk) begin
    if (srst) begin
      ack_q <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en) begin
      ack_q <= req && !ack_q;
      if (req && !ack_q && !wb_we_i) begin
        if (hit_buf)
          wb_dat_o <= {24'h00_0000, rxbuf_q};
        else if (hit_con1)
          wb_dat_o <= {24'h00_0000, con1_val};
        else if (hit_stat)
          wb_dat_o <= {24'h00_0000, stat_val};
        else
          wb_dat_o <= 32'h0000_0000;
      end else if (!req) begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // ========================================================================
  // Control register one
  // Hardware set of the error flags wins over a software clear in the same cycle.
  wire ev_live = en_q;
  wire buf_collide = ev_live && wr_buf && eng_tx_busy_i;
  wire buf_accept = ev_live && wr_buf && !eng_tx_busy_i;
  wire rx_live = ev_live && eng_rx_done_i;
  // Reading the buffer on the same edge frees it for the incoming byte
  wire buf_full_now = bf_q && !rd_buf;
  wire rx_overflow = rx_live && buf_full_now && !mode_host && (mode_spi_client || mode_i2c_client);

  always @(posedge core_clk) begin
    if (srst) begin
      write_collision_flag_q <= 1'b0;
      ovf_q <= 1'b0;
      en_q <= 1'b0;
      ckp_q <= 1'b0;
      mode_q <= 4'h0;
    end else if (clk_en) begin
      if (buf_collide)
        write_collision_flag_q <= 1'b1;
      else if (wr_con1)
        write_collision_flag_q <= wb_dat_i[`SSPSC_C1_WRITE_COLLISION_FLAG];
      if (rx_overflow)
        ovf_q <= 1'b1;
      else if (wr_con1)
        ovf_q <= wb_dat_i[`SSPSC_C1_OVF];
      if (wr_con1) begin
        en_q <= wb_dat_i[`SSPSC_C1_EN];
        ckp_q <= wb_dat_i[`SSPSC_C1_CKP];
        mode_q <= wb_dat_i[`SSPSC_C1_MODE_HI:`SSPSC_C1_MODE_LO];
      end
    end
  end

  // ========================================================================
  // Data buffer and buffer-full flag
  // The engine raises rx_done after the eighth data bit, before ACK or Stop.
  always @(posedge core_clk) begin
    if (srst) begin
      bf_q <= 1'b0;
      rxbuf_q <= 8'h00;
      tx_load_o <= 1'b0;
      tx_data_o <= 8'h00;
    end else if (clk_en) begin
      tx_load_o <= buf_accept;
      if (buf_accept) begin
        tx_data_o <= wb_dat_i[7:0];
        bf_q <= 1'b1;
      end else if (rx_live && !rx_overflow) begin
        rxbuf_q <= eng_rx_byte_i;
        bf_q <= 1'b1;
      end else if (rx_live) begin
        bf_q <= 1'b1;
      end else if (ev_live && eng_tx_done_i) begin
        bf_q <= 1'b0;
      end else if (rd_buf) begin
        bf_q <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Client read/write capture and address reload
  always @(posedge core_clk) begin
    if (srst) begin
      rw_client_q <= 1'b0;
      ua_q <= 1'b0;
    end else if (clk_en) begin
      if (ev_live && mode_i2c_client && eng_addr_match_i)
        rw_client_q <= eng_addr_rw_i;
      else if (cond_start || cond_stop || (ev_live && eng_nack_i))
        rw_client_q <= 1'b0;
      if (!en_q || !mode_i2c_ten)
        ua_q <= 1'b0;
      else if (eng_addr_reload_set_i)
        ua_q <= 1'b1;
      else if (eng_addr_reload_clr_i)
        ua_q <= 1'b0;
    end
  end

  // ========================================================================
  // Clock pin control
  // SPI host drives push-pull; I2C client only ever pulls low, so the line
  // stays open-drain and a disabled port leaves the pin to general I/O.
  wire spi_host_drive = en_q && mode_spi_host;
  wire i2c_stretch = en_q && mode_i2c_client && !ckp_q;

  assign serial_clock_pin_oe = spi_host_drive || i2c_stretch;
  assign serial_clock_pin_o = spi_host_drive ? (eng_tx_busy_i ? eng_sck_i : ckp_q) : 1'b0;

  // ========================================================================
  // Engine-facing configuration
  assign port_enable_o = en_q;
  assign port_mode_select_o = mode_q;
  // Without select control the client always listens
  assign spi_client_selected_o = en_q && mode_spi_client &&
                                 ((mode_q == `SSPSC_M_SPI_C_NOSEL) || !sel_n_now);

endmodule

// File: testbench/sspsc_properties.sv
// Purpose: Port-level properties of sspsc_top.
// Assumes: One clock domain, core_clk, with synchronous srst.
// Notes:   Bound to the design from the bench top file.
`timescale 1ns/1ps
module sspsc_props (
  // Clock and reset
  input wire core_clk,
  input wire srst,
  input wire clk_en,
  // Register bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  // Pins and engine
  input wire serial_clock_pin_o,
  input wire serial_clock_pin_oe,
  input wire eng_tx_busy_i,
  input wire eng_sck_i,
  input wire [4:0] seq_requests_i,
  input wire tx_load_o,
  input wire [7:0] tx_data_o,
  input wire port_enable_o,
  input wire [3:0] port_mode_select_o,
  input wire port_active_o,
  input wire spi_client_selected_o,
  input wire cond_event_o
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // ====
  // Helpers
  wire wr_c1 = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i == 12'h790 && clk_en;
  wire wr_buf = wb_ack_o && wb_we_i && wb_adr_i == 12'h78C && !eng_tx_busy_i;
  // ====
  // Properties
  chk_ack_time: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
    else $error("ack not one cycle after request");
  chk_mode_load: assert property (wr_c1 |=> port_mode_select_o == $past(wb_dat_i[3:0]))
    else $error("mode field not loaded");
  chk_enable_load: assert property (wr_c1 |=> port_enable_o == $past(wb_dat_i[5]))
    else $error("enable bit not loaded");
  chk_pins_off: assert property (!port_enable_o |-> !serial_clock_pin_oe)
    else $error("clock pin driven while disabled");
  chk_active_req: assert property (|seq_requests_i |-> port_active_o)
    else $error("active missing with request");
  chk_spi_drive: assert property (port_enable_o && port_mode_select_o == 4'h0 && eng_tx_busy_i
    |-> serial_clock_pin_oe && serial_clock_pin_o == eng_sck_i)
    else $error("host clock not driven");
  chk_spi_nosel: assert property (port_enable_o && port_mode_select_o == 4'h5 |-> spi_client_selected_o)
    else $error("client not listening");
  chk_cond_mode: assert property (cond_event_o |-> $past(port_enable_o && port_mode_select_o[3:1] == 3'b111))
    else $error("condition event in wrong mode");
  chk_load_clean: assert property ($rose(tx_load_o) |-> $past(wr_buf))
    else $error("load without clean buffer write");
  chk_tx_data: assert property ($rose(tx_load_o) |-> tx_data_o == $past(wb_dat_i[7:0]))
    else $error("loaded byte differs from written byte");
  cover property (cond_event_o);
  cover property (tx_load_o);
  cover property (wr_c1);
endmodule

// File: testbench/sspsc_bus_model.sv
// Purpose: External bus partner making Start and Stop conditions.
// Assumes: Open-drain clock and data lines with pull-ups.
// Notes:   Link clock stands still between frames; select stays high.
`timescale 1ns/1ps
module sspsc_bus_model (
  // Bus lines
  output logic scl,
  output logic sda,
  output logic ss_n
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    ss_n = 1'b1;
  end
  // ====
  // Conditions, half of a 48 ns link period per step
  task start_c();
    sda = 1'b0;
    #24;
    scl = 1'b0;
    #24;
  endtask
  task stop_c();
    sda = 1'b0;
    #24;
    scl = 1'b1;
    #24;
    sda = 1'b1;
    #24;
  endtask
endmodule

// File: testbench/sspsc_top_bench.sv
// Purpose: Self-checking bench for sspsc_top.
// Assumes: Engine events come from the bench as one-cycle pulses.
// Notes:   Reads queue expected bytes; a monitor compares on ack.
`timescale 1ns/1ps
module sspsc_top_bench;
  logic core_clk = 0, srst = 1, clk_en = 1;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [11:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 0;
  logic busy = 0, arw = 0, sck = 0;
  logic [4:0] ev = 0, req = 0;
  logic [7:0] rxb = 0, rb;
  logic [7:0] exp_q[$];
  int bad_count = 0, samples_checked = 0, seed = 32'h7bb1_4ab4;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, scl_o, scl_oe, m_scl, m_sda, m_ss_n;
  // Open-drain clock: low wins
  wire scl_w = m_scl & (scl_oe ? scl_o : 1'b1);
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  sspsc_top i_dut (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .serial_clock_pin_i(scl_w), .serial_clock_pin_o(scl_o), .serial_clock_pin_oe(scl_oe),
    .serial_data_pin_i(m_sda), .client_select_pin_n_i(m_ss_n), .eng_tx_busy_i(busy), .eng_tx_done_i(ev[0]),
    .eng_rx_done_i(ev[1]), .eng_rx_byte_i(rxb), .eng_addr_match_i(ev[2]), .eng_addr_rw_i(arw),
    .eng_nack_i(ev[3]), .eng_addr_reload_set_i(ev[4]), .eng_addr_reload_clr_i(1'b0), .eng_sck_i(sck),
    .seq_requests_i(req), .tx_load_o(), .tx_data_o(), .port_enable_o(), .port_mode_select_o(),
    .port_active_o(), .spi_client_selected_o(), .cond_event_o());
  sspsc_bus_model i_bus (.scl(m_scl), .sda(m_sda), .ss_n(m_ss_n));
  // ====
  // Checking
  always @(posedge core_clk) begin
    if (wb_ack_o === 1'b1 && !wb_we_i && exp_q.size() > 0) begin
      samples_checked++;
      if (wb_dat_o !== {24'h0, exp_q[0]}) begin
        $display("[ERR] %0t read %h want %h", $time, wb_dat_o, exp_q[0]);
        bad_count++;
      end
      void'(exp_q.pop_front());
    end
  end
  task final_report();
    if (exp_q.size() != 0) begin
      $display("[ERR] %0t %0d reads never answered", $time, exp_q.size());
      bad_count++;
    end
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ====
  // Drivers
  task wb(input logic we, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      $display("[ERR] %0t no ack", $time);
      bad_count++;
      disable scen;
    end
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge core_clk);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    wb(0, a, 8'h00);
  endtask
  task pulse(input logic [4:0] m);
    ev <= m;
    @(posedge core_clk);
    ev <= 0;
    repeat (3) @(posedge core_clk);
  endtask
  task cond(input logic st);
    if (st)
      i_bus.start_c();
    else
      i_bus.stop_c();
    repeat (4) @(posedge core_clk);
  endtask
  // ====
  // Scenarios
  initial begin
    begin : scen
      repeat (8) @(posedge core_clk);
      srst <= 0;
      @(posedge core_clk);
      rd(12'h790, 8'h00);
      rd(12'h794, 8'h00);
      rd(12'h7F0, 8'h00);
      wb(1, 12'h790, 8'h25);
      rd(12'h790, 8'h25);
      wb(1, 12'h790, 8'h3E);
      req <= 5'($random(seed));
      rd(12'h790, 8'h3E);
      req <= 0;
      $display("test control done");
      cond(1);
      rd(12'h794, 8'h08);
      arw <= 1;
      pulse(5'h04);
      rd(12'h794, 8'h0C);
      pulse(5'h08);
      rd(12'h794, 8'h08);
      cond(0);
      rd(12'h794, 8'h10);
      cond(1);
      rd(12'h794, 8'h08);
      $display("test conditions done");
      rb = 8'($random(seed));
      rxb <= rb;
      pulse(5'h02);
      rd(12'h794, 8'h09);
      rxb <= ~rb;
      pulse(5'h02);
      rd(12'h790, 8'h7E);
      rd(12'h78C, rb);
      rd(12'h794, 8'h08);
      wb(1, 12'h790, 8'h0E);
      rd(12'h794, 8'h00);
      $display("test receive done");
      wb(1, 12'h790, 8'h20);
      busy <= 1;
      sck <= 1;
      wb(1, 12'h78C, 8'h5A);
      rd(12'h790, 8'hA0);
      busy <= 0;
      sck <= 0;
      wb(1, 12'h790, 8'h20);
      wb(1, 12'h78C, 8'hA5);
      rd(12'h790, 8'h20);
      wb(1, 12'h790, 8'h2B);
      wb(1, 12'h78C, 8'h3C);
      busy <= 1;
      rd(12'h794, 8'h05);
      busy <= 0;
      pulse(5'h01);
      rd(12'h794, 8'h00);
      pulse(5'h02);
      rxb <= rb ^ 8'h0F;
      pulse(5'h02);
      rd(12'h790, 8'h2B);
      rd(12'h78C, rb ^ 8'h0F);
      wb(1, 12'h790, 8'h2F);
      pulse(5'h10);
      rd(12'h794, 8'h02);
      // A byte event while frozen must leave the buffer flag alone
      clk_en <= 0;
      pulse(5'h02);
      clk_en <= 1;
      rd(12'h794, 8'h02);
      $display("test transmit done");
      srst <= 1;
      repeat (2) @(posedge core_clk);
      srst <= 0;
      @(posedge core_clk);
      rd(12'h790, 8'h00);
      rd(12'h794, 8'h00);
      $display("test reset done");
    end
    final_report();
  end
endmodule
bind sspsc_top sspsc_props i_props (.core_clk, .srst, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_ack_o, .serial_clock_pin_o, .serial_clock_pin_oe, .eng_tx_busy_i, .eng_sck_i,
  .seq_requests_i, .tx_load_o, .tx_data_o, .port_enable_o, .port_mode_select_o, .port_active_o, .spi_client_selected_o,
  .cond_event_o);
